// ===== rtl/quad_nibble_defines.svh
/*
 * Constants of the nibble port pin logic: reset values, timing and
 * alternate-function pin positions.
 * Assumes a single system clock shared with the core.
 */
`ifndef QUAD_NIBBLE_DEFINES_SVH
`define QUAD_NIBBLE_DEFINES_SVH

// system clock rate
`define CLOCK_MHZ 125
// least time an input must hold a new level on the filtered path
`define NOISE_MIN_NS 64
// rounded up to whole cycles
`define NOISE_CYCLES ((`NOISE_MIN_NS * `CLOCK_MHZ + 999) / 1000)

// output latch reset values
`define LATCH_RESET 4'h0
`define OPEN_DRAIN_RESET 4'hF

// alternate functions on the upper port a pins
`define PIN_A_SCK 1
`define PIN_A_SERIAL_OUT_BUS0 2
`define PIN_A_SERIAL_IN_BUS1 3
// alternate functions on port c pins
`define PIN_C_TIMER_A 0
`define PIN_C_TIMER_B 1
`define PIN_C_CLK_TIMER_C 2
`define PIN_C_TONE 3
// alternate inputs on port b pins
`define PIN_B_FILT_IRQ 0
`define PIN_B_ASYNC_IRQ 1
`define PIN_B_TEST_EVENT_BC 2
`define PIN_B_EVENT_A 3

`endif

// ===== rtl/quad_nibble_pkg.sv
/*
 * Types shared by the nibble port pin logic: pin bundles, core writes,
 * configuration bits and alternate-function outputs.
 * Assumes the core holds the configuration bits in its own registers.
 */
`default_nettype none

package quad_nibble_pkg;

    // one nibble per port, 32 pins in all
    typedef struct packed {
        logic [3:0] high;
        logic [3:0] low;
        logic [3:0] keys;
        logic [3:0] od;
        logic [3:0] d;
        logic [3:0] c;
        logic [3:0] b;
        logic [3:0] a;
    } pins_type;

    typedef enum logic [2:0] {
        sel_a,
        sel_c,
        sel_d,
        sel_od,
        sel_keys,
        sel_low,
        sel_high,
        sel_wide
    } port_sel_type;

    typedef struct packed {
        logic strobe;
        port_sel_type sel;
        logic [7:0] data;
    } core_write_type;

    typedef struct packed {
        logic pu_a_upper;
        logic pu_b;
        logic pu_c;
        logic pu_d;
        logic pu_keys;
        logic pu_low;
        logic pu_high;
        logic [2:0] dir_a_upper;
        logic dir_c;
        logic [3:0] dir_d;
        logic [3:0] dir_keys;
        logic dir_low;
        logic dir_high;
        logic seg_low;
        logic seg_high;
        logic filt_rise;
        logic filt_noise;
        logic async_rise;
        logic clk_not_timer_c;
        logic bias_disconnect;
    } port_config_type;

    typedef struct packed {
        logic [2:0] timer;
        logic prog_clk;
        logic tone;
        logic sck;
        logic so;
        logic sb1;
    } alt_out_type;

endpackage

`default_nettype wire

// ===== rtl/pin_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes the inputs may change at any time relative to the clock.
 */
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/quad_nibble_port_pin_logic.sv
/*
 * Pin logic of eight nibble ports: output latches, direction, pull-ups,
 * segment sharing, alternate functions and edge detectors.
 * Assumes the core supplies configuration levels and write strobes on
 * this clock, and that pads resolve out/oe/pull-up into the pin level.
 */
// What this block does
// (RULE1) port a: pin 0 input only, pins 1-3 bidirectional, input after reset
// (RULE2) one pull-up setting covers port a pins 1-3 together
// (RULE3) port b input only, four pull-ups switched together
// (RULE4) port c bidirectional nibble, input at reset, grouped pull-ups
// (RULE5) ports d and keys: per-bit direction, input at reset, grouped pull-ups
// (RULE6) open-drain nibble only pulls low, released after reset
// (RULE7) low segment nibble bidirectional, grouped pull-ups, written with high as a byte
// (RULE8) high nibble bidirectional, segment outputs in reversed bit order
// (RULE9) software keeps pull-ups off on pins used as segment outputs
// (RULE10) port a pin 0 requests an interrupt on both edges
// (RULE11) two port b interrupts, selectable edge; first may use noise filter
// (RULE12) port b pin 2 rising edge sets a test flag, no interrupt
// (RULE13) falling edge on any key return input sets a flag
// (RULE14) upper port b pins feed timer event inputs, two share one pin
// (RULE15) port a upper pins carry serial clock and data, input at reset
// (RULE16) bias output drives low with split resistor, otherwise high impedance
// (RULE17) port d pins 0 and 1 act only as ordinary port bits
// (RULE18) enabled alternate outputs override latches; reads return sampled pins
`default_nettype none

`include "quad_nibble_defines.svh"

module quad_nibble_port_pin_logic #(
    parameter int NOISE_CYCLES = `NOISE_CYCLES,
    parameter bit SPLIT_RESISTOR = 1'h1
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire quad_nibble_pkg::core_write_type core_write,
    input wire quad_nibble_pkg::port_config_type port_cfg,
    input wire quad_nibble_pkg::alt_out_type alt_value,
    input wire quad_nibble_pkg::alt_out_type alt_enable,
    input wire logic [7:0] seg_data,
    input wire logic test_flag_clear,
    input wire logic key_flag_clear,
    input wire quad_nibble_pkg::pins_type pin_in,
    output var quad_nibble_pkg::pins_type pin_out,
    output var quad_nibble_pkg::pins_type pin_oe,
    output var quad_nibble_pkg::pins_type pin_pullup,
    output var quad_nibble_pkg::pins_type read_pins,
    output logic irq_both_edge,
    output logic irq_filtered,
    output logic irq_async,
    output logic rising_test_flag,
    output logic key_return_flag,
    output logic event_in_a,
    output logic event_in_b,
    output logic event_in_c,
    output logic sck_in,
    output logic serial_out_bus0_in,
    output logic serial_in_bus1_in,
    output logic bias_out,
    output logic bias_oe
);

    localparam int CW = $clog2(NOISE_CYCLES + 1);
    quad_nibble_pkg::pins_type out_d;
    quad_nibble_pkg::pins_type oe_d;
    quad_nibble_pkg::pins_type pu_d;
    quad_nibble_pkg::pins_type sync_w;

    logic [2:0] lat_a_q;
    logic [3:0] lat_c_q;
    logic [3:0] lat_d_q;
    logic [3:0] lat_od_q;
    logic [3:0] lat_keys_q;
    logic [3:0] lat_low_q;
    logic [3:0] lat_high_q;

    logic prev_a0_q;
    logic prev_b1_q;
    logic prev_b2_q;
    logic [3:0] prev_keys_q;
    logic prev_filt_src_q;
    logic filt_level_q;
    logic [CW-1:0] filt_cnt_q;
    logic filt_src;

    function automatic logic edge_hit(input logic prev, input logic now, input logic rise);
        return rise ? (!prev && now) : (prev && !now);
    endfunction
    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction

    // every pin read passes two flops first
    pin_sync #(
        .WIDTH(32)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async_in(pin_in),
        .sync_out(sync_w)
    );

    assign read_pins = sync_w; // see (RULE18)

    assign event_in_a = sync_w.b[`PIN_B_EVENT_A]; // see (RULE14)
    assign event_in_b = sync_w.b[`PIN_B_TEST_EVENT_BC]; // see (RULE14)
    assign event_in_c = sync_w.b[`PIN_B_TEST_EVENT_BC]; // see (RULE14)
    assign sck_in = sync_w.a[`PIN_A_SCK]; // see (RULE15)
    assign serial_out_bus0_in = sync_w.a[`PIN_A_SERIAL_OUT_BUS0]; // see (RULE15)
    assign serial_in_bus1_in = sync_w.a[`PIN_A_SERIAL_IN_BUS1]; // see (RULE15)

    // output latches; a byte write fills both segment nibbles at once
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lat_a_q <= 3'h0;
            lat_c_q <= `LATCH_RESET;
            lat_d_q <= `LATCH_RESET;
            lat_od_q <= `OPEN_DRAIN_RESET; // see (RULE6)
            lat_keys_q <= `LATCH_RESET;
            lat_low_q <= `LATCH_RESET;
            lat_high_q <= `LATCH_RESET;
        end else if (core_write.strobe) begin
            unique case (core_write.sel)
                quad_nibble_pkg::sel_a: lat_a_q <= core_write.data[3:1];
                quad_nibble_pkg::sel_c: lat_c_q <= core_write.data[3:0];
                quad_nibble_pkg::sel_d: lat_d_q <= core_write.data[3:0];
                quad_nibble_pkg::sel_od: lat_od_q <= core_write.data[3:0];
                quad_nibble_pkg::sel_keys: lat_keys_q <= core_write.data[3:0];
                quad_nibble_pkg::sel_low: lat_low_q <= core_write.data[3:0];
                quad_nibble_pkg::sel_high: lat_high_q <= core_write.data[3:0];
                quad_nibble_pkg::sel_wide: begin
                    lat_low_q <= core_write.data[3:0]; // see (RULE7)
                    lat_high_q <= core_write.data[7:4]; // see (RULE7)
                end
            endcase
        end
    end

    // pad drive, before the output flops
    always_comb begin
        out_d = '0;
        oe_d = '0;
        pu_d = '0;
        // pin 0 never drives and has no pull-up
        out_d.a = {lat_a_q, 1'h0}; // see (RULE1)
        oe_d.a = {port_cfg.dir_a_upper, 1'h0}; // see (RULE1)
        pu_d.a = {{3{port_cfg.pu_a_upper}}, 1'h0}; // see (RULE2)
        if (alt_enable.sck) begin
            out_d.a[`PIN_A_SCK] = alt_value.sck; // see (RULE15)
            oe_d.a[`PIN_A_SCK] = 1'h1;
        end
        if (alt_enable.so) begin
            out_d.a[`PIN_A_SERIAL_OUT_BUS0] = alt_value.so; // see (RULE15)
            oe_d.a[`PIN_A_SERIAL_OUT_BUS0] = 1'h1;
        end
        if (alt_enable.sb1) begin
            out_d.a[`PIN_A_SERIAL_IN_BUS1] = alt_value.sb1; // see (RULE15)
            oe_d.a[`PIN_A_SERIAL_IN_BUS1] = 1'h1;
        end
        pu_d.b = {4{port_cfg.pu_b}}; // see (RULE3)
        out_d.c = lat_c_q;
        oe_d.c = {4{port_cfg.dir_c}}; // see (RULE4)
        pu_d.c = {4{port_cfg.pu_c}}; // see (RULE4)
        if (alt_enable.timer[0]) begin
            out_d.c[`PIN_C_TIMER_A] = alt_value.timer[0]; // see (RULE18)
            oe_d.c[`PIN_C_TIMER_A] = 1'h1;
        end
        if (alt_enable.timer[1]) begin
            out_d.c[`PIN_C_TIMER_B] = alt_value.timer[1]; // see (RULE18)
            oe_d.c[`PIN_C_TIMER_B] = 1'h1;
        end
        // shared pin: clock output and third timer, one at a time
        if (port_cfg.clk_not_timer_c ? alt_enable.prog_clk : alt_enable.timer[2]) begin
            out_d.c[`PIN_C_CLK_TIMER_C] = port_cfg.clk_not_timer_c ? alt_value.prog_clk
                                                                    : alt_value.timer[2]; // see (RULE18)
            oe_d.c[`PIN_C_CLK_TIMER_C] = 1'h1;
        end
        if (alt_enable.tone) begin
            out_d.c[`PIN_C_TONE] = alt_value.tone; // see (RULE18)
            oe_d.c[`PIN_C_TONE] = 1'h1;
        end
        // expansion driver functions are not wired to these pins
        out_d.d = lat_d_q; // see (RULE17)
        oe_d.d = port_cfg.dir_d; // see (RULE5)
        pu_d.d = {4{port_cfg.pu_d}}; // see (RULE5)
        // open drain: data 0 pulls low, 1 releases to the mask pull-up
        out_d.od = 4'h0; // see (RULE6)
        oe_d.od = ~lat_od_q; // see (RULE6)
        out_d.keys = lat_keys_q;
        oe_d.keys = port_cfg.dir_keys; // see (RULE5)
        pu_d.keys = {4{port_cfg.pu_keys}}; // see (RULE5)
        // segment mode wins; pull-ups forced off as a guard behind software
        if (port_cfg.seg_low) begin
            out_d.low = rev4(seg_data[7:4]); // see (RULE8)
            oe_d.low = 4'hF;
        end else begin
            out_d.low = lat_low_q;
            oe_d.low = {4{port_cfg.dir_low}}; // see (RULE7)
            pu_d.low = {4{port_cfg.pu_low}}; // see (RULE9)
        end
        if (port_cfg.seg_high) begin
            out_d.high = rev4(seg_data[3:0]); // see (RULE8)
            oe_d.high = 4'hF;
        end else begin
            out_d.high = lat_high_q;
            oe_d.high = {4{port_cfg.dir_high}}; // see (RULE8)
            pu_d.high = {4{port_cfg.pu_high}}; // see (RULE9)
        end
    end

    // registered pad drive; reset leaves every pin an input
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
        end else begin
            pin_out <= out_d;
            pin_oe <= oe_d;
            pin_pullup <= pu_d;
        end
    end

    // noise filter: a new level must persist for NOISE_CYCLES samples
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            filt_level_q <= 1'h0;
            filt_cnt_q <= '0;
        end else if (sync_w.b[`PIN_B_FILT_IRQ] == filt_level_q) begin
            filt_cnt_q <= '0;
        end else if (filt_cnt_q == CW'(NOISE_CYCLES - 1)) begin
            filt_level_q <= sync_w.b[`PIN_B_FILT_IRQ]; // see (RULE11)
            filt_cnt_q <= '0;
        end else begin
            filt_cnt_q <= filt_cnt_q + CW'(1);
        end
    end

    // switching the path may raise one spurious edge; mask it in the core
    assign filt_src = port_cfg.filt_noise ? filt_level_q : sync_w.b[`PIN_B_FILT_IRQ]; // see (RULE11)

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_a0_q <= 1'h0;
            prev_b1_q <= 1'h0;
            prev_b2_q <= 1'h0;
            prev_keys_q <= 4'h0;
            prev_filt_src_q <= 1'h0;
        end else begin
            prev_a0_q <= sync_w.a[0];
            prev_b1_q <= sync_w.b[`PIN_B_ASYNC_IRQ];
            prev_b2_q <= sync_w.b[`PIN_B_TEST_EVENT_BC];
            prev_keys_q <= sync_w.keys;
            prev_filt_src_q <= filt_src;
        end
    end

    // interrupt requests, one-cycle pulses
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_both_edge <= 1'h0;
            irq_filtered <= 1'h0;
            irq_async <= 1'h0;
        end else begin
            irq_both_edge <= prev_a0_q != sync_w.a[0]; // see (RULE10)
            irq_filtered <= edge_hit(prev_filt_src_q, filt_src, port_cfg.filt_rise); // see (RULE11)
            irq_async <= edge_hit(prev_b1_q, sync_w.b[`PIN_B_ASYNC_IRQ], port_cfg.async_rise); // see (RULE11)
        end
    end

    // test flags: a new edge beats a clear in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rising_test_flag <= 1'h0;
        end else if (edge_hit(prev_b2_q, sync_w.b[`PIN_B_TEST_EVENT_BC], 1'h1)) begin
            rising_test_flag <= 1'h1; // see (RULE12)
        end else if (test_flag_clear) begin
            rising_test_flag <= 1'h0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            key_return_flag <= 1'h0;
        end else if (|(prev_keys_q & ~sync_w.keys)) begin
            key_return_flag <= 1'h1; // see (RULE13)
        end else if (key_flag_clear) begin
            key_return_flag <= 1'h0;
        end
    end

    // bias disconnect: low while fitted and bias_disconnect is clear, else released
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bias_out <= 1'h0;
            bias_oe <= SPLIT_RESISTOR; // see (RULE16)
        end else begin
            bias_out <= 1'h0;
            bias_oe <= SPLIT_RESISTOR && !port_cfg.bias_disconnect; // see (RULE16)
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    sequence s_wide_write;
        core_write.strobe && core_write.sel == quad_nibble_pkg::sel_wide ##1 !port_cfg.seg_low;
    endsequence
    sequence s_od_write;
        core_write.strobe && core_write.sel == quad_nibble_pkg::sel_od;
    endsequence
    property p_a0_input_only;
        pin_oe.a[0] == 1'h0 && pin_pullup.a[0] == 1'h0;
    endproperty
    a_a0_input_only: assert property (p_a0_input_only) else $error("port a pin 0 driven"); // see (RULE1)
    property p_a_upper_pullup;
        1'h1 |=> pin_pullup.a[3:1] == {3{$past(port_cfg.pu_a_upper)}};
    endproperty
    a_a_upper_pullup: assert property (p_a_upper_pullup) else $error("port a pull-up group split"); // see (RULE2)
    property p_b_input_only;
        pin_oe.b == 4'h0 && (pin_pullup.b == 4'h0 || pin_pullup.b == 4'hF);
    endproperty
    a_b_input_only: assert property (p_b_input_only) else $error("port b driven or pull-ups split"); // see (RULE3)
    property p_od_write;
        s_od_write |=> ##1 pin_oe.od == ~$past(core_write.data[3:0], 2) && pin_out.od == 4'h0;
    endproperty
    a_od_write: assert property (p_od_write) else $error("open drain drive wrong"); // see (RULE6)
    property p_wide_write;
        s_wide_write |=> pin_out.low == $past(core_write.data[3:0], 2);
    endproperty
    a_wide_write: assert property (p_wide_write) else $error("byte write missed low nibble"); // see (RULE7)
    property p_seg_reverse;
        port_cfg.seg_high |=> pin_out.high == rev4($past(seg_data[3:0])) && pin_oe.high == 4'hF;
    endproperty
    a_seg_reverse: assert property (p_seg_reverse) else $error("segment order wrong"); // see (RULE8)
    property p_both_edge;
        $changed(sync_w.a[0]) |=> irq_both_edge;
    endproperty
    a_both_edge: assert property (p_both_edge) else $error("both-edge request missed"); // see (RULE10)
    property p_async_edge;
        (port_cfg.async_rise && $rose(sync_w.b[1])) || (!port_cfg.async_rise && $fell(sync_w.b[1]))
            |=> irq_async;
    endproperty
    a_async_edge: assert property (p_async_edge) else $error("async request missed"); // see (RULE11)
    property p_filter_quiet;
        port_cfg.filt_noise && $past(port_cfg.filt_noise) && $stable(filt_level_q) |=> !irq_filtered;
    endproperty
    a_filter_quiet: assert property (p_filter_quiet) else $error("filtered request without filtered edge"); // see (RULE11)
    property p_test_rise;
        $rose(sync_w.b[2]) |=> rising_test_flag ##1 (rising_test_flag || $past(test_flag_clear));
    endproperty
    a_test_rise: assert property (p_test_rise) else $error("test flag not set"); // see (RULE12)
    property p_key_fall;
        |($past(sync_w.keys) & ~sync_w.keys) |=> key_return_flag;
    endproperty
    a_key_fall: assert property (p_key_fall) else $error("key flag not set"); // see (RULE13)
    property p_tone_override;
        alt_enable.tone |=> pin_out.c[3] == $past(alt_value.tone) && pin_oe.c[3];
    endproperty
    a_tone_override: assert property (p_tone_override) else $error("alternate output not driven"); // see (RULE18)
    property p_bias;
        1'h1 |=> bias_out == 1'h0 && bias_oe == (SPLIT_RESISTOR && !$past(port_cfg.bias_disconnect));
    endproperty
    a_bias: assert property (p_bias) else $error("bias output wrong"); // see (RULE16)

endmodule

`default_nettype wire

// ===== test/board_model.sv
/*
 * Board side of the pin logic: pads, external drivers and pull-ups.
 * Assumes the bench raises ext_en on every input pin that it drives.
 */
`default_nettype none

module board_model (
    input wire logic clock,
    input wire quad_nibble_pkg::pins_type pad_out,
    input wire quad_nibble_pkg::pins_type pad_oe,
    input wire quad_nibble_pkg::pins_type pad_pu,
    input wire quad_nibble_pkg::pins_type ext_val,
    input wire quad_nibble_pkg::pins_type ext_en,
    output var quad_nibble_pkg::pins_type pad_level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] float_q = 32'h0;

    // undriven pads wander, so a stale level never passes for a real one
    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    // device drive wins, then board drive, then pull-up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pad_oe[i]) begin
                pad_level[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_level[i] = ext_val[i];
            end else if (pad_pu[i]) begin
                pad_level[i] = 1'h1;
            end else begin
                pad_level[i] = float_q[i];
            end
        end
    end
endmodule

`default_nettype wire

// ===== test/quad_nibble_port_pin_logic_bench.sv
/*
 * Bench of the nibble port pin logic: the driver notes expectations,
 * a watcher compares them with the outputs.
 * Assumes board_model resolves the pads from both sides.
 */
`default_nettype none

module quad_nibble_port_pin_logic_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int k; logic [31:0] m; logic [31:0] e;} note_type;
    logic clock = 1'h0;
    logic arst_n;
    quad_nibble_pkg::core_write_type cw;
    quad_nibble_pkg::port_config_type cfg;
    quad_nibble_pkg::alt_out_type alt_v, alt_e;
    logic [7:0] seg;
    logic tclr, kclr;
    quad_nibble_pkg::pins_type pin_in, pin_out, pin_oe, pin_pu, rd_pins, ext_val, ext_en;
    logic irq_b, irq_f, irq_a, tflag, kflag, ev_a, ev_b, ev_c, bias_out, bias_oe, ser_ck, ser_do, ser_di;
    logic [7:0] cnt_b = 8'h0, cnt_f = 8'h0, cnt_a = 8'h0;
    logic [31:0] obs [0:6];
    string names [0:6] = '{"pin_out", "pin_oe", "pin_pullup", "read_pins", "flags", "bias", "irq_counts"};
    note_type q[$];
    event look;
    int err_total = 0, check_count = 0, cyc = 0;
    logic [7:0] r8;
    logic [3:0] rd, ro, rc, rdir;
    logic [31:0] e;

    quad_nibble_port_pin_logic #(.NOISE_CYCLES(2), .SPLIT_RESISTOR(1'h1)) dut_u (
        .clock(clock), .arst_n(arst_n), .core_write(cw), .port_cfg(cfg),
        .alt_value(alt_v), .alt_enable(alt_e), .seg_data(seg),
        .test_flag_clear(tclr), .key_flag_clear(kclr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu), .read_pins(rd_pins),
        .irq_both_edge(irq_b), .irq_filtered(irq_f), .irq_async(irq_a),
        .rising_test_flag(tflag), .key_return_flag(kflag), .event_in_a(ev_a),
        .event_in_b(ev_b), .event_in_c(ev_c), .sck_in(ser_ck), .serial_out_bus0_in(ser_do),
        .serial_in_bus1_in(ser_di), .bias_out(bias_out), .bias_oe(bias_oe)
    );

    board_model board_u (
        .clock(clock), .pad_out(pin_out), .pad_oe(pin_oe), .pad_pu(pin_pu),
        .ext_val(ext_val), .ext_en(ext_en), .pad_level(pin_in)
    );

    always #4 clock = ~clock;

    // pulses are counted, so a missed or doubled one shows later
    always @(posedge clock) begin
        if (arst_n) begin // pulses unknown until reset reaches the flops
            cnt_b <= cnt_b + 8'(irq_b);
            cnt_f <= cnt_f + 8'(irq_f);
            cnt_a <= cnt_a + 8'(irq_a);
        end
    end

    always_comb begin
        obs[0] = pin_out;
        obs[1] = pin_oe;
        obs[2] = pin_pu;
        obs[3] = rd_pins;
        obs[4] = {24'h0, ser_ck, ser_do, ser_di, ev_a, ev_b, ev_c, kflag, tflag};
        obs[5] = {30'h0, bias_oe, bias_out};
        obs[6] = {8'h0, cnt_b, cnt_f, cnt_a};
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    always @(look) begin
        note_type n;
        while (q.size() > 0) begin
            n = q.pop_front();
            check(names[n.k], obs[n.k] & n.m, n.e);
        end
    end

    task automatic note(int k, logic [31:0] m, logic [31:0] x);
        q.push_back('{k, m, x & m});
        ->look;
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(quad_nibble_pkg::port_sel_type s, logic [7:0] d);
        @(posedge clock);
        cw <= {1'h1, s, d};
    endtask

    task automatic pin(int b, logic v, int n);
        @(posedge clock);
        ext_val[b] <= v;
        settle(n);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h1AA68C61));
        arst_n = 1'h0;
        cw = '0;
        cfg = '0;
        cfg.filt_noise = 1'h1;
        cfg.filt_rise = 1'h1;
        cfg.async_rise = 1'h1;
        alt_v = '0;
        alt_e = '0;
        seg = 8'h0;
        tclr = 1'h0;
        kclr = 1'h0;
        ext_val = '0;
        ext_en = 32'h00FF00FF;
        repeat (2) @(posedge clock);
        arst_n <= 1'h1;
        #1;
        note(1, 32'hFFFFFFFF, 32'h0);
        note(2, 32'hFFFFFFFF, 32'h0);
        note(0, 32'h000F0000, 32'h0);
        note(5, 32'h3, 32'h2);
        $display("test reset done");
        @(posedge clock);
        cfg.pu_a_upper <= 1'h1;
        cfg.pu_b <= 1'h1;
        cfg.pu_c <= 1'h1;
        cfg.pu_d <= 1'h1;
        cfg.pu_keys <= 1'h1;
        cfg.pu_low <= 1'h1;
        cfg.pu_high <= 1'h1;
        settle(2);
        note(2, 32'hFFFFFFFF, 32'hFFF0FFFE);
        $display("test pullups done");
        @(posedge clock);
        seg <= 8'($urandom());
        cfg.seg_low <= 1'h1;
        cfg.seg_high <= 1'h1;
        cfg.pu_low <= 1'h0;
        cfg.pu_high <= 1'h0;
        settle(2);
        for (int i = 0; i < 4; i++) begin
            e[31 - i] = seg[i];
            e[27 - i] = seg[4 + i];
        end
        note(0, 32'hFF000000, e);
        note(1, 32'hFF000000, 32'hFF000000);
        $display("test segments done");
        @(posedge clock);
        r8 = 8'($urandom());
        rd = 4'($urandom());
        ro = 4'($urandom());
        rc = 4'($urandom());
        rdir = 4'($urandom());
        cfg.seg_low <= 1'h0;
        cfg.seg_high <= 1'h0;
        cfg.dir_low <= 1'h1;
        cfg.dir_high <= 1'h1;
        cfg.dir_c <= 1'h1;
        cfg.dir_d <= rdir;
        cfg.dir_a_upper <= 3'h7;
        wr(quad_nibble_pkg::sel_wide, r8);
        wr(quad_nibble_pkg::sel_d, {4'h0, rd});
        wr(quad_nibble_pkg::sel_od, {4'h0, ro});
        wr(quad_nibble_pkg::sel_c, {4'h0, rc});
        wr(quad_nibble_pkg::sel_a, 8'h0F);
        @(posedge clock);
        cw.strobe <= 1'h0;
        settle(3);
        note(0, 32'hFF0FFF0E, {r8, 8'h0, rd, rc, 8'h0E});
        note(1, 32'hFF0FFF0F, {8'hFF, 4'h0, ~ro, rdir, 8'hF0, 4'hE});
        @(posedge clock);
        alt_e.tone <= 1'h1;
        alt_v.tone <= ~rc[3];
        cfg.bias_disconnect <= 1'h1;
        settle(2);
        note(0, 32'h00000800, {20'h0, ~rc[3], 11'h0});
        note(5, 32'h3, 32'h0);
        $display("test writes done");
        pin(0, 1'h1, 5);
        note(3, 32'h1, 32'h1);
        pin(0, 1'h0, 5);
        note(6, 32'h00FF0000, 32'h00020000);
        pin(6, 1'h1, 5);
        note(4, 32'hFF, 32'hED);
        @(posedge clock);
        tclr <= 1'h1;
        @(posedge clock);
        tclr <= 1'h0;
        settle(2);
        note(4, 32'h1, 32'h0);
        pin(5, 1'h1, 5);
        pin(5, 1'h0, 5);
        note(6, 32'hFF, 32'h01);
        pin(4, 1'h1, 0);
        pin(4, 1'h0, 6);
        note(6, 32'hFF00, 32'h0);
        pin(4, 1'h1, 10);
        pin(4, 1'h0, 10);
        note(6, 32'hFF00, 32'h0100);
        pin(22, 1'h1, 5);
        note(4, 32'h2, 32'h0);
        pin(22, 1'h0, 5);
        note(4, 32'h2, 32'h2);
        pin(7, 1'h1, 5);
        note(4, 32'h10, 32'h10);
        $display("test events done");
        settle(1);
        test_done();
    end
endmodule

`default_nettype wire
